// File: shared/complex_math_pkg.sv
// Overview of operation
// - Parallel second operation reads pre-update destination values.
// - Parallel first operation reads sources before second writes.
// - Nine 32-bit data registers; some operations exclude ninth.
// - Half-register access only for registers zero to seven.
// - High float immediate fills upper half, lower zero.
// - Low immediate fills low half; full immediate fills word.
// - Shift immediates are 5-bit unsigned, zero to 31.
// - Exactly two separate transition-bit registers.
// - Operand fields list destinations first, then sources.
// - Two-cycle operation issues every cycle, result one later.
// - Host stalls freeze all state; store and check pulses drop to zero.
package complex_math_pkg;

    // =========================================================
    // Register file shape
    // =========================================================
    localparam int unsigned NUM_DATA_REGS = 9;
    localparam int unsigned NUM_TRANS_REGS = 2;
    localparam int unsigned WORD_W = 32;
    localparam int unsigned HALF_W = 16;
    localparam int unsigned SHIFT_W = 5;
    localparam int unsigned REG_IDX_W = 4;
    localparam logic [3:0] NINTH_REG_IDX = 4'h8;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
    localparam logic [15:0] HALF_ZERO = 16'h0000;
    localparam logic [4:0] SHIFT_ZERO = 5'h00;

    // =========================================================
    // Decoded operations
    // =========================================================
    typedef enum logic [3:0] {
        OP_NOP,
        OP_MOVE_REG,
        OP_WORD_LOAD,
        OP_WORD_STORE,
        OP_HALF_LOAD,
        OP_HALF_STORE,
        OP_FLOAT_HIGH_IMM,
        OP_FLOAT_LOW_IMM,
        OP_FLOAT_FULL_IMM,
        OP_SET_SHIFT,
        OP_COMPLEX_ADD,
        OP_COMPLEX_MULTIPLY,
        OP_TRANS_LOAD,
        OP_TRANS_STORE
    } main_op_t;

    typedef enum logic [1:0] {
        PAR_NONE,
        PAR_WORD_LOAD,
        PAR_WORD_STORE
    } par_op_t;

    // Destination fields precede source fields, as operands are written.
    typedef struct packed {
        logic valid;
        main_op_t op;
        logic [3:0] dest_a;
        logic [3:0] dest_b;
        logic [3:0] src_a;
        logic [3:0] src_b;
        logic half_high;
        logic [31:0] imm;
        logic [31:0] mem_data;
        par_op_t par_op;
        logic [3:0] par_reg;
        logic [31:0] par_mem_data;
    } instr_t;

    typedef struct packed {
        logic store_valid;
        logic [31:0] store_data;
        logic par_store_valid;
        logic [31:0] par_store_data;
    } store_out_t;

    typedef struct packed {
        logic delay_src_hazard;
        logic delay_dest_hazard;
        logic dup_dest_hazard;
        logic operand_reject;
    } check_out_t;

endpackage : complex_math_pkg

// File: rtl/complex_math_unit.sv
module complex_math_unit
    import complex_math_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic stall_i,
    input wire instr_t instr_i,
    output store_out_t store_o,
    output check_out_t check_o,
    output logic [SHIFT_W-1:0] shift_amount_o,
    output logic pending_busy_o
);

    // =========================================================
    // State
    // =========================================================
    typedef struct packed {
        logic [NUM_DATA_REGS-1:0][WORD_W-1:0] data_register_n;
        logic [NUM_TRANS_REGS-1:0][WORD_W-1:0] trans_reg;
        logic pend_valid;
        logic [3:0] pend_dest_a;
        logic [3:0] pend_dest_b;
        logic [WORD_W-1:0] pend_res_a;
        logic [WORD_W-1:0] pend_res_b;
        logic [SHIFT_W-1:0] shift_amount;
        store_out_t store;
        check_out_t check;
    } state_t;

    state_t state_q;
    state_t state_d;

    function automatic logic is_data_reg(input logic [3:0] idx);
        return idx <= NINTH_REG_IDX;
    endfunction : is_data_reg

    function automatic logic is_half_reg(input logic [3:0] idx);
        return idx < NINTH_REG_IDX;
    endfunction : is_half_reg

    function automatic logic reads_a(input main_op_t op);
        return op inside {OP_MOVE_REG, OP_WORD_STORE, OP_HALF_STORE,
                          OP_COMPLEX_ADD, OP_COMPLEX_MULTIPLY};
    endfunction : reads_a

    function automatic logic reads_b(input main_op_t op);
        return op inside {OP_COMPLEX_ADD, OP_COMPLEX_MULTIPLY};
    endfunction : reads_b

    function automatic logic writes_a(input main_op_t op);
        return op inside {OP_MOVE_REG, OP_WORD_LOAD, OP_HALF_LOAD, OP_FLOAT_HIGH_IMM,
                          OP_FLOAT_LOW_IMM, OP_FLOAT_FULL_IMM, OP_COMPLEX_ADD,
                          OP_COMPLEX_MULTIPLY};
    endfunction : writes_a

    // =========================================================
    // Next state
    // =========================================================
    logic signed [HALF_W-1:0] a_hi, a_lo, b_hi, b_lo;
    logic signed [WORD_W-1:0] p_hh, p_ll, p_hl, p_lh;
    logic [WORD_W-1:0] rd_a, rd_b, rd_par;
    logic bad_operand, pend_hit_src, pend_hit_dst, dup_dest;
    logic [WORD_W-1:0] wr_word;

    always_comb begin
        state_d = state_q;
        state_d.store.store_valid = 1'b0;
        state_d.store.par_store_valid = 1'b0;
        state_d.check = '0;

        // All reads sample the registers before any write of this cycle.
        rd_a = is_data_reg(instr_i.src_a) ? state_q.data_register_n[instr_i.src_a] : WORD_ZERO;
        rd_b = is_data_reg(instr_i.src_b) ? state_q.data_register_n[instr_i.src_b] : WORD_ZERO;
        rd_par = is_data_reg(instr_i.par_reg) ? state_q.data_register_n[instr_i.par_reg]
                                               : WORD_ZERO;
        a_hi = rd_a[WORD_W-1:HALF_W];
        a_lo = rd_a[HALF_W-1:0];
        b_hi = rd_b[WORD_W-1:HALF_W];
        b_lo = rd_b[HALF_W-1:0];
        p_hh = WORD_W'(a_hi * b_hi);
        p_ll = WORD_W'(a_lo * b_lo);
        p_hl = WORD_W'(a_hi * b_lo);
        p_lh = WORD_W'(a_lo * b_hi);
        wr_word = WORD_ZERO;

        // Operand legality: nine data registers, halves on the first eight only.
        bad_operand = 1'b0;
        case (instr_i.op)
            OP_HALF_LOAD: begin
                bad_operand = !is_half_reg(instr_i.dest_a);
            end
            OP_HALF_STORE: begin
                bad_operand = !is_half_reg(instr_i.src_a);
            end
            OP_COMPLEX_MULTIPLY: begin
                bad_operand = !is_half_reg(instr_i.dest_a) || !is_half_reg(instr_i.dest_b) ||
                              !is_half_reg(instr_i.src_a) || !is_half_reg(instr_i.src_b);
            end
            OP_TRANS_LOAD, OP_TRANS_STORE: begin
                bad_operand = 32'(instr_i.dest_a) >= NUM_TRANS_REGS;
            end
            default: begin
                bad_operand = (writes_a(instr_i.op) && !is_data_reg(instr_i.dest_a)) ||
                              (reads_a(instr_i.op) && !is_data_reg(instr_i.src_a)) ||
                              (reads_b(instr_i.op) && !is_data_reg(instr_i.src_b));
            end
        endcase
        if (instr_i.par_op != PAR_NONE && !is_data_reg(instr_i.par_reg)) begin
            bad_operand = 1'b1;
        end

        // Conflict checker against the result still in flight, and for a parallel load onto a destination of the same instruction.
        pend_hit_src = 1'b0;
        pend_hit_dst = 1'b0;
        dup_dest = 1'b0;
        if (state_q.pend_valid && instr_i.valid) begin
            pend_hit_src = (reads_a(instr_i.op) && (instr_i.src_a == state_q.pend_dest_a ||
                                                    instr_i.src_a == state_q.pend_dest_b)) ||
                           (reads_b(instr_i.op) && (instr_i.src_b == state_q.pend_dest_a ||
                                                    instr_i.src_b == state_q.pend_dest_b)) ||
                           (instr_i.par_op == PAR_WORD_STORE &&
                            (instr_i.par_reg == state_q.pend_dest_a ||
                             instr_i.par_reg == state_q.pend_dest_b));
            pend_hit_dst = (writes_a(instr_i.op) && (instr_i.dest_a == state_q.pend_dest_a ||
                                                     instr_i.dest_a == state_q.pend_dest_b)) ||
                           (instr_i.par_op == PAR_WORD_LOAD &&
                            (instr_i.par_reg == state_q.pend_dest_a ||
                             instr_i.par_reg == state_q.pend_dest_b));
        end
        if (instr_i.valid && instr_i.par_op == PAR_WORD_LOAD) begin
            dup_dest = (writes_a(instr_i.op) && instr_i.par_reg == instr_i.dest_a) ||
                       (instr_i.op == OP_COMPLEX_MULTIPLY &&
                        instr_i.par_reg == instr_i.dest_b);
        end

        if (!stall_i) begin
            // The delay slot retires the in-flight result whether or not it issues.
            if (state_q.pend_valid) begin
                state_d.data_register_n[state_q.pend_dest_a] = state_q.pend_res_a;
                state_d.data_register_n[state_q.pend_dest_b] = state_q.pend_res_b;
                state_d.pend_valid = 1'b0;
            end
            state_d.check.delay_src_hazard = pend_hit_src;
            state_d.check.delay_dest_hazard = pend_hit_dst;
            state_d.check.dup_dest_hazard = dup_dest;
            state_d.check.operand_reject = instr_i.valid && bad_operand;

            if (instr_i.valid && !bad_operand) begin
                case (instr_i.op)
                    OP_MOVE_REG: begin
                        state_d.data_register_n[instr_i.dest_a] = rd_a;
                    end
                    OP_WORD_LOAD: begin
                        state_d.data_register_n[instr_i.dest_a] = instr_i.mem_data;
                    end
                    OP_WORD_STORE: begin
                        state_d.store.store_valid = 1'b1;
                        state_d.store.store_data = rd_a;
                    end
                    OP_HALF_LOAD: begin
                        wr_word = state_q.data_register_n[instr_i.dest_a];
                        if (instr_i.half_high) begin
                            wr_word[WORD_W-1:HALF_W] = instr_i.mem_data[HALF_W-1:0];
                        end else begin
                            wr_word[HALF_W-1:0] = instr_i.mem_data[HALF_W-1:0];
                        end
                        state_d.data_register_n[instr_i.dest_a] = wr_word;
                    end
                    OP_HALF_STORE: begin
                        state_d.store.store_valid = 1'b1;
                        state_d.store.store_data = {HALF_ZERO, instr_i.half_high ?
                                                    rd_a[WORD_W-1:HALF_W] : rd_a[HALF_W-1:0]};
                    end
                    OP_FLOAT_HIGH_IMM: begin
                        state_d.data_register_n[instr_i.dest_a] =
                            {instr_i.imm[HALF_W-1:0], HALF_ZERO};
                    end
                    OP_FLOAT_LOW_IMM: begin
                        state_d.data_register_n[instr_i.dest_a][HALF_W-1:0] =
                            instr_i.imm[HALF_W-1:0];
                    end
                    OP_FLOAT_FULL_IMM: begin
                        state_d.data_register_n[instr_i.dest_a] = instr_i.imm;
                    end
                    OP_SET_SHIFT: begin
                        state_d.shift_amount = instr_i.imm[SHIFT_W-1:0];
                    end
                    OP_COMPLEX_ADD: begin
                        state_d.data_register_n[instr_i.dest_a] =
                            {a_hi + b_hi, a_lo + b_lo};
                    end
                    OP_COMPLEX_MULTIPLY: begin
                        // Real part to the first destination, imaginary to the second.
                        state_d.pend_valid = 1'b1;
                        state_d.pend_dest_a = instr_i.dest_a;
                        state_d.pend_dest_b = instr_i.dest_b;
                        state_d.pend_res_a = p_ll - p_hh;
                        state_d.pend_res_b = p_hl + p_lh;
                    end
                    OP_TRANS_LOAD: begin
                        state_d.trans_reg[instr_i.dest_a[0]] = instr_i.mem_data;
                    end
                    OP_TRANS_STORE: begin
                        state_d.store.store_valid = 1'b1;
                        state_d.store.store_data = state_q.trans_reg[instr_i.dest_a[0]];
                    end
                    default: begin
                    end
                endcase
                case (instr_i.par_op)
                    PAR_WORD_LOAD: begin
                        state_d.data_register_n[instr_i.par_reg] = instr_i.par_mem_data;
                    end
                    PAR_WORD_STORE: begin
                        state_d.store.par_store_valid = 1'b1;
                        state_d.store.par_store_data = rd_par;
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    // =========================================================
    // Outputs
    // =========================================================
    assign store_o = state_q.store;
    assign check_o = state_q.check;
    assign shift_amount_o = state_q.shift_amount;
    assign pending_busy_o = state_q.pend_valid;

endmodule : complex_math_unit

// File: dv/complex_math_unit_assertions.sv
module complex_math_unit_assertions
    import complex_math_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic stall_i,
    input wire instr_t instr_i,
    input wire store_out_t store_o,
    input wire check_out_t check_o,
    input wire logic [SHIFT_W-1:0] shift_amount_o,
    input wire logic pending_busy_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic go;
    logic mul;
    logic mul_ok;
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (reset_i);
    assign go = !stall_i && instr_i.valid;
    assign mul = go && instr_i.op == OP_COMPLEX_MULTIPLY;
    assign mul_ok = mul && !instr_i.dest_a[3] && !instr_i.dest_b[3] && !instr_i.src_a[3]
        && !instr_i.src_b[3] && !instr_i.par_reg[3];
    // =========================================
    // Timing, stall and operand checks
    // =========================================
    a_mul_busy: assert property (mul_ok |=> pending_busy_o)
        else $error("busy missing after multiply");
    a_busy_drop: assert property (pending_busy_o && !stall_i && !mul |=> !pending_busy_o)
        else $error("busy held too long");
    a_stall_hold: assert property (stall_i |=> $stable(pending_busy_o)
        && $stable(shift_amount_o) && $stable(store_o.store_data))
        else $error("state moved during stall");
    a_stall_quiet: assert property (stall_i |=> !store_o.store_valid
        && !store_o.par_store_valid && check_o == '0)
        else $error("pulse during stall");
    a_shift_value: assert property (go && instr_i.op == OP_SET_SHIFT
        |=> shift_amount_o == $past(instr_i.imm[4:0]))
        else $error("shift amount wrong");
    a_half_ninth: assert property (go && instr_i.op == OP_HALF_LOAD
        && instr_i.dest_a == NINTH_REG_IDX |=> check_o.operand_reject)
        else $error("half access to ninth register taken");
    a_trans_range: assert property (go && instr_i.op == OP_TRANS_LOAD
        && instr_i.dest_a > 4'h1 |=> check_o.operand_reject)
        else $error("third transition register taken");
    a_reg_range: assert property (go && instr_i.op == OP_WORD_LOAD
        && instr_i.dest_a > NINTH_REG_IDX |=> check_o.operand_reject)
        else $error("register index above eight taken");
    a_dup_flag: assert property (mul_ok && instr_i.par_op == PAR_WORD_LOAD
        && instr_i.par_reg == instr_i.dest_a |=> check_o.dup_dest_hazard)
        else $error("duplicate destination not flagged");
    a_store_pulse: assert property (go && instr_i.op == OP_WORD_STORE
        && !instr_i.src_a[3] |=> store_o.store_valid)
        else $error("word store missing");
    c_mul_stall: cover property (mul_ok ##1 stall_i [*3]);
    c_dup: cover property (check_o.dup_dest_hazard);
    c_reject: cover property (check_o.operand_reject);
endmodule : complex_math_unit_assertions

bind complex_math_unit complex_math_unit_assertions i_chk (.core_clk_i(core_clk_i),
    .reset_i(reset_i), .stall_i(stall_i), .instr_i(instr_i), .store_o(store_o),
    .check_o(check_o), .shift_amount_o(shift_amount_o), .pending_busy_o(pending_busy_o));

// File: dv/host_issuer.sv
module host_issuer
    import complex_math_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic stall_i,
    input wire logic push_i,
    input wire logic raw_i,
    input wire instr_t req_i,
    output instr_t instr_o,
    output logic accept_o
);
    timeunit 1ns;
    timeprecision 1ps;
    instr_t last_q;
    logic clash;
    logic dup;
    function automatic logic hit(input logic [3:0] r);
        return last_q.valid && last_q.op == OP_COMPLEX_MULTIPLY
            && (r == last_q.dest_a || r == last_q.dest_b);
    endfunction : hit
    // =========================================
    // Issue gate
    // =========================================
    // A clash is held back while a no-op fills the slot; raw mode sends it anyway.
    assign clash = hit(req_i.dest_a) || hit(req_i.dest_b) || hit(req_i.src_a)
        || hit(req_i.src_b) || (req_i.par_op != PAR_NONE && hit(req_i.par_reg));
    assign dup = req_i.par_op == PAR_WORD_LOAD && req_i.par_reg == req_i.dest_a;
    assign accept_o = push_i && !stall_i && (raw_i || (!clash && !dup));
    assign instr_o = accept_o ? req_i : '0;
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            last_q <= '0;
        end else if (!stall_i) begin
            last_q <= instr_o;
        end
    end
endmodule : host_issuer

// File: dv/testbench.sv
module testbench import complex_math_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic stall_i = 1'b0;
    logic push = 1'b0;
    logic raw = 1'b0;
    logic clr_chk = 1'b0;
    logic accept;
    logic busy;
    logic [4:0] shift;
    instr_t req = '0;
    instr_t instr;
    store_out_t store;
    check_out_t chk;
    check_out_t seen_chk = '0;
    logic [31:0] seen_data = '0;
    logic [31:0] seen_par = '0;
    int num_errors = 0;
    int n_checks = 0;
    complex_math_unit i_dut (.core_clk_i(core_clk_i), .reset_i(reset_i), .stall_i(stall_i),
        .instr_i(instr), .store_o(store), .check_o(chk), .shift_amount_o(shift),
        .pending_busy_o(busy));
    host_issuer i_host (.core_clk_i(core_clk_i), .reset_i(reset_i), .stall_i(stall_i),
        .push_i(push), .raw_i(raw), .req_i(req), .instr_o(instr), .accept_o(accept));
    always #10 core_clk_i = ~core_clk_i;
    // Pulses are gathered mid-cycle so scenarios can judge them afterwards.
    always @(negedge core_clk_i) begin
        seen_chk <= clr_chk ? chk : seen_chk | chk;
        if (store.store_valid) seen_data <= store.store_data;
        if (store.par_store_valid) seen_par <= store.par_store_data;
    end
    // =========================================
    // Helpers
    // =========================================
    task automatic test_done(input bit hung);
        if (hung) num_errors++;
        $display("checks=%0d errors=%0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : test_done
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    function automatic instr_t mk(main_op_t op, logic [3:0] da, db, sa, sb, logic [31:0] v);
        return '{1'b1, op, da, db, sa, sb, 1'b0, v, v, PAR_NONE, 4'h0, 32'h0};
    endfunction : mk
    function automatic instr_t par(instr_t i, par_op_t p, logic [3:0] r, logic [31:0] d);
        instr_t t = i;
        t.par_op = p;
        t.par_reg = r;
        t.par_mem_data = d;
        return t;
    endfunction : par
    task automatic issue(input instr_t i);
        int n = 0;
        req <= i;
        push <= 1'b1;
        do begin
            @(posedge core_clk_i);
            n++;
        end while (accept !== 1'b1 && n < 20);
        if (accept !== 1'b1) test_done(1'b1);
    endtask : issue
    task automatic idle(input int n);
        push <= 1'b0;
        repeat (n) @(posedge core_clk_i);
    endtask : idle
    task automatic rd(input main_op_t op, input logic [3:0] r, input logic [31:0] exp);
        issue(mk(op, r, 4'h0, r, 4'h0, '0));
        idle(2);
        check(seen_data, exp);
    endtask : rd
    task automatic haz(input bit r, input instr_t a, input instr_t b, input check_out_t exp);
        clr_chk <= 1'b1;
        raw <= r;
        issue(a);
        clr_chk <= 1'b0;
        issue(b);
        idle(3);
        check(32'(seen_chk), 32'(exp));
    endtask : haz
    // =========================================
    // Scenarios
    // =========================================
    task automatic s_imm;
        issue(mk(OP_FLOAT_HIGH_IMM, 4'h1, 4'h0, 4'h0, 4'h0, 32'h0000_3f80));
        rd(OP_WORD_STORE, 4'h1, 32'h3f80_0000);
        issue(mk(OP_FLOAT_LOW_IMM, 4'h1, 4'h0, 4'h0, 4'h0, 32'h0000_1234));
        rd(OP_WORD_STORE, 4'h1, 32'h3f80_1234);
        issue(mk(OP_FLOAT_FULL_IMM, 4'h2, 4'h0, 4'h0, 4'h0, 32'hdead_beef));
        rd(OP_WORD_STORE, 4'h2, 32'hdead_beef);
        issue(mk(OP_SET_SHIFT, 4'h0, 4'h0, 4'h0, 4'h0, 32'h0000_003f));
        idle(2);
        check(32'(shift), 32'h0000_001f);
    endtask : s_imm
    task automatic s_mul;
        issue(mk(OP_WORD_LOAD, 4'h0, 4'h0, 4'h0, 4'h0, 32'h0001_0002));
        issue(mk(OP_WORD_LOAD, 4'h1, 4'h0, 4'h0, 4'h0, 32'h0003_0004));
        issue(mk(OP_WORD_LOAD, 4'h3, 4'h0, 4'h0, 4'h0, 32'h1111_1111));
        issue(par(mk(OP_COMPLEX_MULTIPLY, 4'h3, 4'h2, 4'h1, 4'h0, '0), PAR_WORD_STORE, 4'h3, '0));
        rd(OP_WORD_STORE, 4'h3, 32'h0000_0005);
        check(seen_par, 32'h1111_1111);
        rd(OP_WORD_STORE, 4'h2, 32'h0000_000a);
        issue(par(mk(OP_COMPLEX_MULTIPLY, 4'h5, 4'h4, 4'h1, 4'h0, '0), PAR_WORD_LOAD, 4'h0,
            32'h0007_0007));
        issue(mk(OP_COMPLEX_MULTIPLY, 4'h7, 4'h6, 4'h1, 4'h0, '0));
        rd(OP_WORD_STORE, 4'h5, 32'h0000_0005);
        rd(OP_WORD_STORE, 4'h4, 32'h0000_000a);
        rd(OP_WORD_STORE, 4'h6, 32'h0000_0031);
    endtask : s_mul
    task automatic s_stall;
        issue(mk(OP_COMPLEX_MULTIPLY, 4'h3, 4'h2, 4'h1, 4'h0, '0));
        push <= 1'b0;
        stall_i <= 1'b1;
        repeat (3) @(posedge core_clk_i);
        check(32'(busy), 32'h1);
        stall_i <= 1'b0;
        rd(OP_WORD_STORE, 4'h3, 32'h0000_0007);
    endtask : s_stall
    task automatic s_haz;
        instr_t m = mk(OP_COMPLEX_MULTIPLY, 4'h3, 4'h2, 4'h1, 4'h0, '0);
        instr_t nop = mk(OP_NOP, 4'h0, 4'h0, 4'h0, 4'h0, '0);
        haz(1'b1, m, mk(OP_COMPLEX_ADD, 4'h5, 4'h0, 4'h3, 4'h1, '0), 4'h8);
        haz(1'b1, m, mk(OP_WORD_LOAD, 4'h3, 4'h0, 4'h0, 4'h0, '0), 4'h4);
        haz(1'b1, par(m, PAR_WORD_LOAD, 4'h3, '0), nop, 4'h2);
        haz(1'b0, m, mk(OP_COMPLEX_ADD, 4'h5, 4'h0, 4'h3, 4'h1, '0), 4'h0);
        haz(1'b0, mk(OP_HALF_LOAD, 4'h8, 4'h0, 4'h0, 4'h0, '0), nop, 4'h1);
        haz(1'b0, mk(OP_COMPLEX_MULTIPLY, 4'h3, 4'h2, 4'h8, 4'h0, '0), nop, 4'h1);
        haz(1'b0, mk(OP_TRANS_LOAD, 4'h2, 4'h0, 4'h0, 4'h0, '0), nop, 4'h1);
        haz(1'b0, mk(OP_WORD_LOAD, 4'h9, 4'h0, 4'h0, 4'h0, '0), nop, 4'h1);
    endtask : s_haz
    task automatic s_reg;
        instr_t t = mk(OP_HALF_LOAD, 4'h7, 4'h0, 4'h0, 4'h0, 32'h0000_abcd);
        t.half_high = 1'b1;
        issue(mk(OP_WORD_LOAD, 4'h8, 4'h0, 4'h0, 4'h0, 32'h8888_0008));
        rd(OP_WORD_STORE, 4'h8, 32'h8888_0008);
        issue(mk(OP_WORD_LOAD, 4'h7, 4'h0, 4'h0, 4'h0, 32'h1234_5678));
        issue(t);
        rd(OP_WORD_STORE, 4'h7, 32'habcd_5678);
        issue(mk(OP_COMPLEX_ADD, 4'h5, 4'h0, 4'h7, 4'h8, '0));
        rd(OP_WORD_STORE, 4'h5, 32'h3455_5680);
        issue(mk(OP_MOVE_REG, 4'h6, 4'h0, 4'h7, 4'h0, '0));
        rd(OP_HALF_STORE, 4'h6, 32'h0000_5678);
        t.op = OP_HALF_STORE;
        t.src_a = 4'h6;
        issue(t);
        idle(2);
        check(seen_data, 32'h0000_abcd);
        issue(mk(OP_TRANS_LOAD, 4'h1, 4'h0, 4'h0, 4'h0, 32'h5555_aaaa));
        issue(mk(OP_TRANS_LOAD, 4'h0, 4'h0, 4'h0, 4'h0, 32'h0f0f_0f0f));
        rd(OP_TRANS_STORE, 4'h1, 32'h5555_aaaa);
        rd(OP_TRANS_STORE, 4'h0, 32'h0f0f_0f0f);
    endtask : s_reg
    initial begin
        repeat (6) @(posedge core_clk_i);
        reset_i <= 1'b0;
        @(posedge core_clk_i);
        @(negedge core_clk_i);
        check({store.store_data[27:0], chk}, 32'h0);
        check({26'h0, busy, shift}, 32'h0);
        check(32'({store.store_valid, store.par_store_valid}), 32'h0);
        @(posedge core_clk_i);
        s_imm;
        s_mul;
        s_stall;
        s_haz;
        s_reg;
        test_done(1'b0);
    end
endmodule : testbench
